//--- src/rst_seq_pkg.sv
// Constants, types and register layout for the reset sequencer and supply monitor.
// Assumes a single 100 MHz CPU clock and an APB register port.
package rst_seq_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] ADDR_INTEGRITY  = 8'h00;
  localparam logic [7:0] ADDR_RC_TRIM    = 8'h04;
  localparam logic [7:0] ADDR_CONFIG     = 8'h08;
  localparam logic [7:0] ADDR_STATUS     = 8'h0c;

  localparam int BIT_FAST_LOCK  = 7;
  localparam int BIT_TRIM1      = 6;
  localparam int BIT_TRIM0      = 5;
  localparam int BIT_WDG_FLAG   = 4;
  localparam int BIT_LOCK       = 3;
  localparam int BIT_LV_FLAG    = 2;
  localparam int BIT_AUX_FLAG   = 1;
  localparam int BIT_AUX_IE     = 0;

  localparam logic [1:0] TRIM_LOW_RESET = 2'h3;
  localparam logic [7:0] RC_TRIM_RESET  = 8'hff;
  localparam logic [15:0] RESET_VECTOR  = 16'hfffe;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SHORT_DELAY_CYC  = 256;
  localparam int LONG_DELAY_CYC   = 4096;
  localparam int FETCH_CYC        = 2;
  localparam int WDG_OUT_NS       = 100;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int WDG_OUT_CYC      = (WDG_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_STARTUP_CYC  = 64;
  localparam int CNT_W            = 13;

  typedef enum logic [1:0] {
    CLK_SRC_RC,
    CLK_SRC_EXT,
    CLK_SRC_XTAL
  } clk_src_e;

  typedef enum {
    ST_ACTIVE,
    ST_DELAY,
    ST_PLL,
    ST_FETCH,
    ST_RUN
  } seq_state_e;

  // Status from the analog, clock, watchdog and core side.
  typedef struct packed {
    logic lv_detect;
    logic aux_cmp;
    logic wdg_underflow;
    logic illegal_op;
    logic pll_locked;
    logic fast_pll_locked;
  } sources_s;

  // Power mode, interrupt mask and interrupt acknowledge from the core.
  typedef struct packed {
    logic halt;
    logic wait_mode;
    logic irq_mask;
    logic aux_irq_ack;
  } core_s;

endpackage : rst_seq_pkg

//--- src/reset_sequencer.sv
// Reset sequencer, supply integrity register and auxiliary voltage interrupt.
// Assumes analog and core inputs are asynchronous and are synchronised here.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Accept resets from the external pin, the low-voltage detector and the watchdog.
// - An illegal opcode or prebyte also starts a reset sequence.
// - All sources act through the reset pin, held low during delay.
// - Sequence runs active phase, then cycle delay, then vector fetch.
// - Delay is 256 cycles for RC or external clock, 4096 for crystal.
// - The vector fetch phase takes exactly two clock cycles.
// - The program counter loads from the fixed vector at FFFEh-FFFFh.
// - With multiplier enabled, clock is withheld for an extra startup delay.
// - The crystal oscillator keeps running during reset.
// - A low reset pin is detected asynchronously, even with no clock.
// - The reset pin is an input and an open-drain output with pull-up.
// - On watchdog underflow the pin is driven low for a minimum width.
// - While undervoltage is signalled the reset pin stays low.
// - Auxiliary flag and interrupt only work when low-voltage detector enabled.
// - The auxiliary flag is a read-only live copy of the comparator.
// - Aux interrupt needs its enable set and the global mask cleared.
// - With interrupt enabled, a threshold crossing requests an interrupt.
// - Wait mode no effect; aux interrupt wakes from wait, not halt.
// - In halt the integrity register is frozen; detector keeps running.
// - Integrity register bit layout as listed, reset pattern 0110 0xx0.
// - Fast lock flag is hardware owned and follows the fast multiplier.
// - RC trim is ten bits: trim register plus integrity bits 6:5.
// - Without the multi-oscillator the default pin is the clock input.
// - Watchdog flag set by watchdog reset; cleared by read, zero write, low-voltage reset.
// - Low-voltage flag set by low-voltage reset, cleared by read, survives others.
// - Multiplier lock flag is hardware only and reads one when locked.
// - Pending aux interrupt clears on entry to its service routine.
module reset_sequencer (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  // APB
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // Reset pin, open drain
  input  wire logic                 rst_pin_i,
  output logic                      rst_pin_o,
  output logic                      rst_pin_oe_o,
  // Sources and core
  input  wire rst_seq_pkg::sources_s src_i,
  input  wire rst_seq_pkg::core_s   core_i,
  input  wire logic                 lvd_enable_i,
  input  wire logic                 pll_enable_i,
  input  wire logic                 multi_osc_used_i,
  input  wire rst_seq_pkg::clk_src_e clk_src_i,
  // Outputs to core and clocks
  output logic                      core_reset_o,
  output logic                      vector_fetch_o,
  output logic      [15:0]          vector_addr_o,
  output logic                      clk_gate_o,
  output logic                      xtal_run_o,
  output logic                      ext_clk_sel_default_o,
  output logic      [9:0]           rc_trim_o,
  output logic                      aux_irq_o,
  output logic                      wake_o
);
  import rst_seq_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic       pin_meta;
  logic       pin_low;
  sources_s   src_meta;
  sources_s   src;
  core_s      core_meta;
  core_s      core;

  always_ff @(posedge clk_i or negedge rst_pin_i) begin
    if (!rst_pin_i) begin
      pin_meta <= 1'b1;
      pin_low  <= 1'b1;
    end else begin
      pin_meta <= 1'b0;
      pin_low  <= pin_meta;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      src_meta  <= '0;
      src       <= '0;
      core_meta <= '0;
      core      <= '0;
    end else begin
      src_meta  <= src_i;
      src       <= src_meta;
      core_meta <= core_i;
      core      <= core_meta;
    end
  end

  // ****************************************************************
  // Reset sources
  // ****************************************************************
  logic lv_active;
  logic wdg_req;
  logic wdg_prev;
  logic ill_prev;
  logic ill_req;
  logic [CNT_W-1:0] wdg_cnt;

  assign lv_active = lvd_enable_i & src.lv_detect;
  assign wdg_req   = src.wdg_underflow & ~wdg_prev;
  assign ill_req   = src.illegal_op & ~ill_prev;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wdg_prev <= 1'b0;
      ill_prev <= 1'b0;
    end else begin
      wdg_prev <= src.wdg_underflow;
      ill_prev <= src.illegal_op;
    end
  end

  // Watchdog output width stretch.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wdg_cnt <= '0;
    end else if (wdg_req || ill_req) begin
      wdg_cnt <= CNT_W'(WDG_OUT_CYC);
    end else if (wdg_cnt != '0) begin
      wdg_cnt <= wdg_cnt - 1'b1;
    end
  end

  // ****************************************************************
  // External pin request
  // ****************************************************************
  logic oe_q1;
  logic oe_q2;
  logic pin_req;

  // The device reads back its own pull, so a low pin counts only once released.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      oe_q1 <= 1'b0;
      oe_q2 <= 1'b0;
    end else begin
      oe_q1 <= rst_pin_oe_o;
      oe_q2 <= oe_q1;
    end
  end

  assign pin_req = pin_low & rst_pin_oe_o & oe_q1 & oe_q2;

  logic any_src;
  assign any_src = lv_active | pin_req | wdg_req | ill_req | (wdg_cnt != '0);

  // ****************************************************************
  // Sequence state machine
  // ****************************************************************
  seq_state_e       state;
  logic [CNT_W-1:0] cnt;

  function automatic logic [CNT_W-1:0] delay_len(input clk_src_e s);
    if (s == CLK_SRC_XTAL) begin
      delay_len = CNT_W'(LONG_DELAY_CYC);
    end else begin
      delay_len = CNT_W'(SHORT_DELAY_CYC);
    end
  endfunction

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state <= ST_ACTIVE;
      cnt   <= '0;
    end else if (any_src) begin
      state <= ST_ACTIVE;
      cnt   <= '0;
    end else begin
      case (state)
        ST_ACTIVE: begin
          state <= ST_DELAY;
          cnt   <= delay_len(clk_src_i) - 1'b1;
        end
        ST_DELAY: begin
          if (cnt == '0) begin
            if (pll_enable_i) begin
              state <= ST_PLL;
              cnt   <= CNT_W'(PLL_STARTUP_CYC - 1);
            end else begin
              state <= ST_FETCH;
              cnt   <= CNT_W'(FETCH_CYC - 1);
            end
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_PLL: begin
          if (cnt == '0) begin
            state <= ST_FETCH;
            cnt   <= CNT_W'(FETCH_CYC - 1);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_FETCH: begin
          if (cnt == '0) begin
            state <= ST_RUN;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // Pin and core outputs, registered.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rst_pin_o      <= 1'b0;
      rst_pin_oe_o   <= 1'b0;
      core_reset_o   <= 1'b1;
      vector_fetch_o <= 1'b0;
      vector_addr_o  <= RESET_VECTOR;
      clk_gate_o     <= 1'b0;
    end else begin
      rst_pin_o      <= 1'b0;
      rst_pin_oe_o   <= ~(any_src || state == ST_ACTIVE || state == ST_DELAY);
      core_reset_o   <= (state != ST_RUN) && (state != ST_FETCH);
      vector_fetch_o <= (state == ST_FETCH) && !any_src;
      vector_addr_o  <= RESET_VECTOR;
      clk_gate_o     <= (state == ST_FETCH) || (state == ST_RUN);
    end
  end

  // ****************************************************************
  // Clock source controls
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      xtal_run_o            <= 1'b0;
      ext_clk_sel_default_o <= 1'b0;
    end else begin
      xtal_run_o            <= (clk_src_i == CLK_SRC_XTAL);
      ext_clk_sel_default_o <= ~multi_osc_used_i;
    end
  end

  // ****************************************************************
  // Integrity register
  // ****************************************************************
  logic       wdg_flag;
  logic       lv_flag;
  logic [1:0] trim_low;
  logic       aux_ie;
  logic [7:0] rc_trim;
  logic       aux_flag;
  logic       aux_prev;
  logic       aux_pend;
  logic       wr_en;
  logic       rd_en;
  logic       frozen;
  logic       integ_rd;
  logic       integ_wr;
  logic [7:0] integ_val;

  assign wr_en    = psel_i & penable_i & pwrite_i;
  assign rd_en    = psel_i & penable_i & ~pwrite_i;
  assign frozen   = core.halt;
  assign integ_rd = rd_en & (paddr_i == ADDR_INTEGRITY);
  assign integ_wr = wr_en & (paddr_i == ADDR_INTEGRITY);
  assign aux_flag = lvd_enable_i & src.aux_cmp;

  assign integ_val = {src.fast_pll_locked, trim_low, wdg_flag, src.pll_locked,
                      lv_flag, aux_flag, aux_ie};

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wdg_flag <= 1'b0;
    end else if (lv_active) begin
      wdg_flag <= 1'b0;
    end else if (wdg_req) begin
      wdg_flag <= 1'b1;
    end else if (!frozen && (integ_rd || (integ_wr && !pwdata_i[BIT_WDG_FLAG]))) begin
      wdg_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      lv_flag <= 1'b0;
    end else if (lv_active) begin
      lv_flag <= 1'b1;
    end else if (!frozen && integ_rd) begin
      lv_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i || any_src) begin
      trim_low <= TRIM_LOW_RESET;
      aux_ie   <= 1'b0;
      rc_trim  <= RC_TRIM_RESET;
    end else if (!frozen && integ_wr) begin
      trim_low <= pwdata_i[BIT_TRIM1:BIT_TRIM0];
      aux_ie   <= pwdata_i[BIT_AUX_IE];
    end else if (!frozen && wr_en && paddr_i == ADDR_RC_TRIM) begin
      rc_trim  <= pwdata_i[7:0];
    end
  end

  // ****************************************************************
  // Auxiliary voltage interrupt
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      aux_prev <= 1'b0;
      aux_pend <= 1'b0;
    end else begin
      aux_prev <= aux_flag;
      if (aux_ie && aux_flag != aux_prev) begin
        aux_pend <= 1'b1;
      end else if (core.aux_irq_ack || !aux_ie) begin
        aux_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      aux_irq_o <= 1'b0;
      wake_o    <= 1'b0;
      rc_trim_o <= {RC_TRIM_RESET, TRIM_LOW_RESET};
    end else begin
      aux_irq_o <= aux_pend & ~core.irq_mask;
      wake_o    <= aux_pend & core.wait_mode & ~core.halt;
      rc_trim_o <= {rc_trim, trim_low};
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      prdata_o  <= '0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
      if (psel_i && !penable_i) begin
        if (paddr_i == ADDR_INTEGRITY) begin
          prdata_o <= {24'h0, integ_val};
        end else if (paddr_i == ADDR_RC_TRIM) begin
          prdata_o <= {24'h0, rc_trim};
        end else if (paddr_i == ADDR_CONFIG) begin
          prdata_o <= {27'h0, multi_osc_used_i, pll_enable_i, lvd_enable_i, clk_src_i};
        end else if (paddr_i == ADDR_STATUS) begin
          prdata_o <= {29'h0, aux_pend, core_reset_o, ~rst_pin_oe_o};
        end else begin
          pslverr_o <= 1'b1;
        end
      end
    end
  end

endmodule // reset_sequencer

`default_nettype wire

//--- verification/reset_seq_chk.sv
// Concurrent checks on reset phase timing and auxiliary interrupt gating.
// Assumes it is bound to reset_sequencer and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module reset_seq_chk (
  // Clock and reset
  input wire logic                  clk_i,
  input wire logic                  resetn_i,
  // Watched ports
  input wire logic                  rst_pin_oe_o,
  input wire rst_seq_pkg::sources_s src_i,
  input wire rst_seq_pkg::core_s    core_i,
  input wire logic                  lvd_enable_i,
  input wire rst_seq_pkg::clk_src_e clk_src_i,
  input wire logic                  vector_fetch_o,
  input wire logic [15:0]           vector_addr_o,
  input wire logic                  aux_irq_o,
  input wire logic                  wake_o
);
  import rst_seq_pkg::*;
  // ****************************************************************
  // Pin low counter and properties
  // ****************************************************************
  int unsigned low_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  always_ff @(posedge clk_i) begin
    if (!resetn_i || rst_pin_oe_o) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  property p_fetch_len;
    $rose(vector_fetch_o) |=> vector_fetch_o ##1 !vector_fetch_o;
  endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("fetch phase length wrong");
  property p_vector;
    vector_fetch_o |-> vector_addr_o == RESET_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("wrong reset vector");
  property p_delay;
    $rose(rst_pin_oe_o) |-> low_cnt >= ((clk_src_i == CLK_SRC_XTAL) ? 4096 : 256);
  endproperty
  a_delay: assert property (p_delay) else $error("pin released too early");
  property p_wdg_out;
    $rose(src_i.wdg_underflow) |-> ##[1:6] (!rst_pin_oe_o [*8]);
  endproperty
  a_wdg_out: assert property (p_wdg_out) else $error("watchdog pulse too short");
  property p_lv_hold;
    src_i.lv_detect [*5] |-> !rst_pin_oe_o;
  endproperty
  a_lv_hold: assert property (p_lv_hold) else $error("pin not held in undervoltage");
  property p_irq_mask;
    core_i.irq_mask [*5] |-> !aux_irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");
  property p_lvd_off;
    !lvd_enable_i [*5] |-> !aux_irq_o;
  endproperty
  a_lvd_off: assert property (p_lvd_off) else $error("detector active while off");
  property p_halt_wake;
    core_i.halt [*5] |-> !wake_o;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("woken from halt");
endmodule // reset_seq_chk
bind reset_sequencer reset_seq_chk chk (.*);
`default_nettype wire

//--- verification/reset_pin_partner.sv
// Board side of the open-drain reset line with its weak pull-up.
// Assumes the bench drives the external pull-down request.
`timescale 1ns/10ps
`default_nettype none
module reset_pin_partner (
  // Device side
  input  wire logic rst_pin_o,
  input  wire logic rst_pin_oe_o,
  // Board side
  input  wire logic ext_low_i,
  output logic      pin_level_o
);
  // ****************************************************************
  // Wired level
  // ****************************************************************
  assign pin_level_o = ((!rst_pin_oe_o && !rst_pin_o) || ext_low_i) ? 1'b0 : 1'b1;
endmodule // reset_pin_partner
`default_nettype wire

//--- verification/tb_reset_sequencer.sv
// Self-checking bench: APB reads, reset sources, auxiliary interrupt.
// Assumes the package, the pin partner and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_reset_sequencer;
  import rst_seq_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic        rst_pin_i, rst_pin_o, rst_pin_oe_o, ext_low, lvd_enable_i, pll_enable_i;
  logic        multi_osc_used_i, core_reset_o, vector_fetch_o, clk_gate_o, xtal_run_o;
  logic        ext_clk_sel_default_o, aux_irq_o, wake_o;
  logic [15:0] vector_addr_o;
  logic [9:0]  rc_trim_o;
  sources_s    src_i;
  core_s       core_i;
  clk_src_e    clk_src_i;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0]  flag_t [5] = '{8'h60, 8'h60, 8'h70, 8'h64, 8'h74};
  int          n_fail = 0, comparisons = 0, k;
  reset_sequencer dut (.*);
  reset_pin_partner pin (.rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
                         .ext_low_i(ext_low), .pin_level_o(rst_pin_i));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [7:0] m);
    int n;
    n = 0;
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back({24'hffffff, m});
    end
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic settle();
    int n;
    n = 0;
    while (core_reset_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) n_fail++;
    while (core_reset_o !== 1'b0 && n < 6000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 6000) n_fail++;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic fire(input int s);
    ext_low <= (s == 0);
    src_i.illegal_op <= (s == 1);
    src_i.wdg_underflow <= (s == 2);
    src_i.lv_detect <= (s == 3);
    repeat (s == 3 ? 20 : 3) @(posedge clk_i);
    ext_low <= 1'b0;
    src_i.illegal_op <= 1'b0;
    src_i.wdg_underflow <= 1'b0;
    src_i.lv_detect <= 1'b0;
    settle();
  endtask
  // ****************************************************************
  // Clock, monitor, watchdog and tests
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (pready_o === 1'b1 && pwrite_i === 1'b0 && exp_q.size() > 0) begin
      check({pslverr_o, prdata_o & msk_q[0]}, exp_q[0] & {1'b1, msk_q[0]});
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
  initial begin
    resetn_i = 1'b0;
    {psel_i, penable_i, pwrite_i, ext_low, pll_enable_i, multi_osc_used_i} = '0;
    {paddr_i, pwdata_i, src_i, core_i} = '0;
    lvd_enable_i = 1'b1;
    clk_src_i = CLK_SRC_RC;
    void'($urandom(35));
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    settle();
    check(33'(clk_gate_o), 33'h1);
    apb(1'b0, ADDR_INTEGRITY, 0, 33'h60, 8'hfb);
    apb(1'b0, ADDR_RC_TRIM, 0, 33'hff, 8'hff);
    apb(1'b0, 8'h10, 0, 33'h100000000, 8'hff);
    check(33'(rc_trim_o), 33'h3ff);
    $display("reset values test done");
    r = $urandom;
    apb(1'b1, ADDR_RC_TRIM, r & 32'hff, 0, 0);
    apb(1'b1, ADDR_INTEGRITY, r & 32'h60, 0, 0);
    apb(1'b0, ADDR_RC_TRIM, 0, 33'(r[7:0]), 8'hff);
    check(33'(rc_trim_o), 33'({r[7:0], r[6:5]}));
    core_i.halt <= 1'b1;
    repeat (4) @(posedge clk_i);
    apb(1'b1, ADDR_INTEGRITY, 32'h1, 0, 0);
    apb(1'b0, ADDR_INTEGRITY, 0, 33'(r & 32'h60), 8'hfb);
    core_i.halt <= 1'b0;
    $display("trim and halt test done");
    for (k = 0; k < 5; k++) begin
      clk_src_i <= (k == 2) ? CLK_SRC_XTAL : CLK_SRC_RC;
      pll_enable_i <= (k == 1);
      fire(k == 4 ? 3 : k);
      if (k == 4) fire(2);
      if (k == 2) check(33'(xtal_run_o), 33'h1);
      apb(1'b0, ADDR_INTEGRITY, 0, 33'(flag_t[k]), k > 2 ? 8'hff : 8'hfb);
      apb(1'b0, ADDR_INTEGRITY, 0, 33'h60, 8'hfb);
      $display("reset source %0d test done", k);
    end
    apb(1'b1, ADDR_INTEGRITY, 32'h61, 0, 0);
    src_i.aux_cmp <= 1'b1;
    src_i.pll_locked <= 1'b1;
    src_i.fast_pll_locked <= 1'b1;
    multi_osc_used_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    check(33'(aux_irq_o), 33'h1);
    check(33'(ext_clk_sel_default_o), 33'h0);
    apb(1'b0, ADDR_INTEGRITY, 0, 33'heb, 8'hff);
    core_i.wait_mode <= 1'b1;
    repeat (5) @(posedge clk_i);
    check(33'(wake_o), 33'h1);
    core_i.halt <= 1'b1;
    repeat (5) @(posedge clk_i);
    check(33'(wake_o), 33'h0);
    core_i <= 4'b0001;
    repeat (5) @(posedge clk_i);
    check(33'(aux_irq_o), 33'h0);
    core_i <= 4'b0010;
    src_i.aux_cmp <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(33'(aux_irq_o), 33'h0);
    core_i <= 4'b0000;
    repeat (5) @(posedge clk_i);
    check(33'(aux_irq_o), 33'h1);
    core_i <= 4'b0001;
    lvd_enable_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    core_i <= 4'b0000;
    src_i.aux_cmp <= 1'b1;
    repeat (6) @(posedge clk_i);
    check(33'(aux_irq_o), 33'h0);
    apb(1'b0, ADDR_INTEGRITY, 0, 33'he9, 8'hfb);
    $display("aux interrupt test done");
    give_verdict();
  end
endmodule // tb_reset_sequencer
`default_nettype wire
